// *** core/sdb_status_bytes.sv ***
`timescale 1ns/100ps
// Overview of operation
// - every status, warning and error bit is active high, one meaning the condition holds.
// - the sensor returns a response byte and a separate detail byte toward the controller.
// - response bit 4 is set while both upstream safety inputs are live.
// - response bit 5 is set while the actuator sits only in the marginal hysteresis range.
// - detail bit 6 in the warning view reports a gateway communication failure.
// - detail bit 4 in the error view reports a wrong or defective actuator, error only.
// - the detail byte shows the cause of a flagged error, or of a flagged warning while no error is flagged.
// - response bit 0 follows both safety outputs being on.
// - response bit 1 is set when actuated with a valid actuator identified.
// - response bit 7 flags an error with outputs off; bit 6 a warning with delayed switch-off.
// - a latched fault clears when its cause is gone and either request bit 7 falls or the guard is open.
module sdb_status_bytes
	import sdb_pkg::*;
(
	input  wire logic                      clk,                  // 250 MHz core clock
	input  wire logic                      srst,                 // sync reset, active high
	input  wire logic                      upstream_input_a,     // pin: upstream channel a live
	input  wire logic                      upstream_input_b,     // pin: upstream channel b live
	input  wire logic                      safety_output_a,      // output a is switched on
	input  wire logic                      safety_output_b,      // output b is switched on
	input  wire logic                      actuator_valid,       // actuated, valid actuator
	input  wire logic                      actuator_marginal,    // actuator in hysteresis range
	input  wire logic                      guard_open,           // guard opened
	input  wire logic                      comm_fail,            // gateway link failure
	input  wire logic [sdb_pkg::NCAUSE-1:0] warn_cause,          // warning-level causes now
	input  wire logic [sdb_pkg::NCAUSE-1:0] err_cause,           // error-level causes now
	input  wire logic [7:0]                reset_request_byte,   // request byte from controller
	input  wire logic                      request_valid,        // request byte strobe
	output logic      [7:0]                sensor_response_byte, // response byte
	output logic      [7:0]                fault_detail_byte     // warning/error detail byte
);
	import sdb_pkg::*;

	typedef struct packed {
		logic [NCAUSE-1:0] err_latch;
		logic              req_b7;
		logic [7:0]        rsp;
		logic [7:0]        det;
	} sdb_state_t;

	sdb_state_t        st_ff;
	sdb_state_t        nxt_st;
	logic [1:0]        in_sync;
	logic              fall_b7;
	logic [NCAUSE-1:0] err_now;
	logic              any_err;
	logic              any_warn;

	sdb_sync2 #(.W(2)) u_in_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({upstream_input_b, upstream_input_a}),
		.q    (in_sync)
	);

	always_comb begin
		nxt_st  = st_ff;
		fall_b7 = 1'b0;
		err_now = '0;
		any_err = 1'b0;
		any_warn = 1'b0;
		if (request_valid) begin
			nxt_st.req_b7 = reset_request_byte[REQ_ERR_RESET];
			fall_b7 = st_ff.req_b7 & ~reset_request_byte[REQ_ERR_RESET];
		end
		// a cause present in this cycle keeps its latch set even on a clear
		for (int i = 0; i < NCAUSE; i++) begin
			if (err_cause[i]) begin
				nxt_st.err_latch[i] = 1'b1;
			end else if (fall_b7 || guard_open) begin
				nxt_st.err_latch[i] = 1'b0;
			end
		end
		err_now  = nxt_st.err_latch;
		any_err  = |err_now;
		// warn_cause[4] has no warning-level meaning, so it raises nothing
		any_warn = (|warn_cause[DET_TEMP:DET_CH_A]) | warn_cause[DET_INTERNAL] | comm_fail;
		// response byte, all bits active high
		nxt_st.rsp               = BYTE_RST; // bits 2,3 stay zero
		nxt_st.rsp[RSP_OUT_ON]   = safety_output_a & safety_output_b;
		nxt_st.rsp[RSP_ACTUATED] = actuator_valid;
		nxt_st.rsp[RSP_INPUTS_OK] = in_sync[0] & in_sync[1];
		nxt_st.rsp[RSP_MARGINAL] = actuator_valid & actuator_marginal;
		nxt_st.rsp[RSP_WARNING]  = any_warn | any_err;
		nxt_st.rsp[RSP_ERROR]    = any_err;
		// detail byte: error view wins over warning view
		nxt_st.det = BYTE_RST;
		if (any_err) begin
			nxt_st.det[DET_INTERNAL:DET_CH_A] = err_now;
		end else begin
			nxt_st.det[DET_TEMP:DET_CH_A] = warn_cause[DET_TEMP:DET_CH_A];
			nxt_st.det[DET_INTERNAL]      = warn_cause[DET_INTERNAL];
			nxt_st.det[DET_COMM]          = comm_fail;
		end
		if (srst) begin
			nxt_st.err_latch = CAUSE_RST;
			nxt_st.req_b7    = 1'b0;
			nxt_st.rsp       = BYTE_RST;
			nxt_st.det       = BYTE_RST;
		end
	end

	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
	end

	assign sensor_response_byte = st_ff.rsp;
	assign fault_detail_byte    = st_ff.det;

	property p_zero_bits;
		@(posedge clk) disable iff (srst)
		sensor_response_byte[3:2] == 2'b00;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("response bits 3:2 not zero");

	property p_out_on;
		@(posedge clk) disable iff (srst)
		(safety_output_a && safety_output_b) |=> sensor_response_byte[0];
	endproperty
	a_out_on: assert property (p_out_on) else $error("output-on bit missing");

	property p_inputs;
		@(posedge clk) disable iff (srst)
		(upstream_input_a && upstream_input_b)[*4] |=> sensor_response_byte[4];
	endproperty
	a_inputs: assert property (p_inputs) else $error("inputs-live bit missing");

	property p_err_detail;
		@(posedge clk) disable iff (srst)
		sensor_response_byte[7] |-> (fault_detail_byte[5:0] != 6'h00);
	endproperty
	a_err_detail: assert property (p_err_detail) else $error("error without cause");

	property p_err_latch;
		@(posedge clk) disable iff (srst)
		err_cause[4] |=> fault_detail_byte[4] && sensor_response_byte[7];
	endproperty
	a_err_latch: assert property (p_err_latch) else $error("actuator error not flagged");

	property p_hold;
		@(posedge clk) disable iff (srst)
		(sensor_response_byte[7] && !guard_open && !request_valid) |=> sensor_response_byte[7];
	endproperty
	a_hold: assert property (p_hold) else $error("error dropped without clear");

	property p_comm;
		@(posedge clk) disable iff (srst)
		(comm_fail && !sensor_response_byte[7]) |-> ##1 sensor_response_byte[6];
	endproperty
	a_comm: assert property (p_comm) else $error("comm warning missing");

	property p_warn_err;
		@(posedge clk) disable iff (srst)
		sensor_response_byte[7] |-> sensor_response_byte[6];
	endproperty
	a_warn_err: assert property (p_warn_err) else $error("error without warning bit");

	property p_actuated;
		@(posedge clk) disable iff (srst)
		$rose(actuator_valid) |=> sensor_response_byte[1];
	endproperty
	a_actuated: assert property (p_actuated) else $error("actuated bit missing");

	property p_marginal;
		@(posedge clk) disable iff (srst)
		(actuator_valid && actuator_marginal) |=> sensor_response_byte[5];
	endproperty
	a_marginal: assert property (p_marginal) else $error("marginal bit missing");

	property p_marg_gate;
		@(posedge clk) disable iff (srst)
		!actuator_valid |=> !sensor_response_byte[5];
	endproperty
	a_marg_gate: assert property (p_marg_gate) else $error("marginal without actuator");

	property p_out_off;
		@(posedge clk) disable iff (srst)
		!(safety_output_a && safety_output_b) |=> !sensor_response_byte[0];
	endproperty
	a_out_off: assert property (p_out_off) else $error("output-on bit stuck");

	property p_inputs_off;
		@(posedge clk) disable iff (srst)
		(!upstream_input_b)[*3] |=> !sensor_response_byte[4];
	endproperty
	a_inputs_off: assert property (p_inputs_off) else $error("inputs-live bit stuck");

	property p_det_msb;
		@(posedge clk) disable iff (srst)
		fault_detail_byte[7] == 1'b0;
	endproperty
	a_det_msb: assert property (p_det_msb) else $error("detail bit 7 set");

	property p_no_warn;
		@(posedge clk) disable iff (srst)
		!sensor_response_byte[6] |-> (fault_detail_byte == 8'h00);
	endproperty
	a_no_warn: assert property (p_no_warn) else $error("detail without warning");

	property p_warn_detail;
		@(posedge clk) disable iff (srst)
		(sensor_response_byte[6] && !sensor_response_byte[7]) |-> (fault_detail_byte[6:0] != 7'h00);
	endproperty
	a_warn_detail: assert property (p_warn_detail) else $error("warning without cause");

	property p_warn_view;
		@(posedge clk) disable iff (srst)
		warn_cause[3] |=> (fault_detail_byte[3] || sensor_response_byte[7]);
	endproperty
	a_warn_view: assert property (p_warn_view) else $error("temperature warning missing");

	property p_comm_det;
		@(posedge clk) disable iff (srst)
		comm_fail |=> (fault_detail_byte[6] || sensor_response_byte[7]);
	endproperty
	a_comm_det: assert property (p_comm_det) else $error("comm detail missing");

	property p_guard_clear;
		@(posedge clk) disable iff (srst)
		(guard_open && (err_cause == '0)) |=> !sensor_response_byte[7];
	endproperty
	a_guard_clear: assert property (p_guard_clear) else $error("guard did not clear");

	property p_set_wins;
		@(posedge clk) disable iff (srst)
		(guard_open && err_cause[0]) |=> (sensor_response_byte[7] && fault_detail_byte[0]);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a live cause");
endmodule // sdb_status_bytes

// *** inc/sdb_pkg.sv ***
package sdb_pkg;
	// response byte bit positions
	localparam int RSP_OUT_ON     = 0;
	localparam int RSP_ACTUATED   = 1;
	localparam int RSP_INPUTS_OK  = 4;
	localparam int RSP_MARGINAL   = 5;
	localparam int RSP_WARNING    = 6;
	localparam int RSP_ERROR      = 7;
	// detail byte bit positions
	localparam int DET_CH_A       = 0;
	localparam int DET_CH_B       = 1;
	localparam int DET_CROSS      = 2;
	localparam int DET_TEMP       = 3;
	localparam int DET_ACTUATOR   = 4;
	localparam int DET_INTERNAL   = 5;
	localparam int DET_COMM       = 6;
	// request byte: error reset bit
	localparam int REQ_ERR_RESET  = 7;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [5:0] CAUSE_RST = 6'h00;
	// width of the cause vector: ch_a, ch_b, cross, temp, actuator, internal
	localparam int NCAUSE = 6;
endpackage : sdb_pkg

// *** core/sdb_sync2.sv ***
`timescale 1ns/100ps
// two-flop synchroniser for a vector of pin levels
module sdb_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,    // core clock
	input  wire logic         srst,   // sync reset, active high
	input  wire logic [W-1:0] d,      // asynchronous levels
	output logic      [W-1:0] q       // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdb_sync_st_t;

	sdb_sync_st_t st_ff;
	sdb_sync_st_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
		if (srst) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
	end

	assign q = st_ff.s2;
endmodule // sdb_sync2

// *** dv/sdb_gateway_model.sv ***
`timescale 1ns/100ps
// gateway side: polls the sensor with one request byte per strobe
module sdb_gateway_model (
	input  wire logic       clk,       // core clock
	output logic      [7:0] req_byte,  // request byte toward the sensor
	output logic            req_valid  // one-cycle strobe
);
	initial begin
		req_byte  = 8'h00;
		req_valid = 1'b0;
	end
	// one byte per poll, bit 7 going high then low asks for a fault reset
	task automatic send(input logic [7:0] b);
		@(negedge clk);
		req_byte  = b;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		req_byte  = ~b; // stale byte must not be taken
	endtask
endmodule // sdb_gateway_model

// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb;
	import sdb_pkg::*;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              in_a = 0, in_b = 0, out_a = 0, out_b = 0;
	logic              act = 0, marg = 0, guard = 0, comm = 0;
	logic [NCAUSE-1:0] warn = '0, err = '0;
	logic [7:0]        req, rsp, det;
	logic              req_v;
	int                n_fail = 0, num_checks = 0;
	always #2 clk = ~clk;
	sdb_gateway_model gw_u (.clk(clk), .req_byte(req), .req_valid(req_v));
	sdb_status_bytes dut_u (.clk(clk), .srst(srst), .upstream_input_a(in_a),
		.upstream_input_b(in_b), .safety_output_a(out_a), .safety_output_b(out_b),
		.actuator_valid(act), .actuator_marginal(marg), .guard_open(guard),
		.comm_fail(comm), .warn_cause(warn), .err_cause(err),
		.reset_request_byte(req), .request_valid(req_v),
		.sensor_response_byte(rsp), .fault_detail_byte(det));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// pins pass a two-flop synchroniser, so allow a few cycles
	task automatic settle();
		repeat (5) @(negedge clk);
	endtask
	initial begin
		repeat (15) @(negedge clk);
		chk(rsp, 8'h00);
		chk(det, 8'h00);
		@(negedge clk);
		srst = 1'b0;
		in_a = 1;
		in_b = 1;
		settle();
		chk(rsp, 8'h10);
		in_b = 0;
		settle();
		chk(rsp, 8'h00);
		in_b = 1;
		out_a = 1;
		act = 1;
		settle();
		chk(rsp, 8'h12);
		out_b = 1;
		settle();
		chk(rsp, 8'h13);
		marg = 1;
		settle();
		chk(rsp, 8'h33);
		act = 0;
		settle();
		chk(rsp, 8'h11);
		act = 1;
		marg = 0;
		$display("test status bits done");
		// warn_cause[4] has no warning meaning: no warning bit, empty detail
		for (int i = 0; i < 6; i++) begin
			warn = NCAUSE'(1 << i);
			settle();
			chk(rsp, (i == 4) ? 8'h13 : 8'h53);
			chk(det, (i == 4) ? 8'h00 : 8'(1 << i));
		end
		warn = '0;
		comm = 1;
		settle();
		chk(rsp, 8'h53);
		chk(det, 8'h40);
		comm = 0;
		$display("test warning detail done");
		out_a = 0;
		out_b = 0;
		warn[3] = 1;
		err[4] = 1;
		settle();
		chk(rsp, 8'hd2);
		chk(det, 8'h10);
		gw_u.send(8'h80);
		gw_u.send(8'h00);
		settle();
		chk(rsp, 8'hd2);
		err = '0;
		warn = '0;
		settle();
		chk(rsp, 8'hd2);
		gw_u.send(8'h80);
		settle();
		chk(rsp, 8'hd2);
		gw_u.send(8'h00);
		settle();
		chk(rsp, 8'h12);
		chk(det, 8'h00);
		err[5] = 1;
		settle();
		chk(det, 8'h20);
		err = '0;
		guard = 1;
		settle();
		chk(rsp, 8'h12);
		err[0] = 1;
		settle();
		chk(rsp, 8'hd2);
		chk(det, 8'h01);
		err = '0;
		settle();
		chk(rsp, 8'h12);
		guard = 0;
		$display("test error latch done");
		err[1] = 1;
		settle();
		chk(det, 8'h02);
		err = '0;
		srst = 1'b1;
		repeat (2) @(negedge clk);
		chk(rsp, 8'h00);
		chk(det, 8'h00);
		srst = 1'b0;
		settle();
		chk(rsp, 8'h12);
		chk(det, 8'h00);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule // tb
